// ===== logic/pfoc_regs.svh
`ifndef PFOC_REGS_SVH
`define PFOC_REGS_SVH
// Printed offsets are register indices; byte address is four times index
`define PFOC_IDX_FAULT_STATUS   12'hF25
`define PFOC_IDX_PIN_LEVEL      12'hF26
`define PFOC_IDX_OUT_OVERRIDE   12'hF27
`define PFOC_IDX_FAULT_CONTROL  12'hF28
`define PFOC_IDX_FAULT_MASK     12'hF24
`define PFOC_IDX_IRQ_STATUS     12'hF40
`define PFOC_IDX_IRQ_ENABLE     12'hF41
`define PFOC_IDX_IRQ_CLEAR      12'hF42
// Status bit positions
`define PFOC_BIT_RELOAD         7
`define PFOC_BIT_DEBUG          5
`define PFOC_BIT_SECOND         2
`define PFOC_BIT_COMPARATOR     1
`define PFOC_BIT_PIN            0
// Control bit positions, then the pin level fault bit
`define PFOC_BIT_DBG_RECOVERY   6
`define PFOC_BIT_SECOND_IRQ     5
`define PFOC_BIT_SECOND_RECOV   4
`define PFOC_BIT_COMP_IRQ       3
`define PFOC_BIT_COMP_RECOV     2
`define PFOC_BIT_PIN_IRQ        1
`define PFOC_BIT_PIN_RECOV      0
`define PFOC_BIT_LEVEL_FAULT    6
// Writable masks and reset values
`define PFOC_STATUS_W1C_MASK    8'hA7
`define PFOC_OVERRIDE_MASK      8'h3F
`define PFOC_CONTROL_MASK       8'h7F
`define PFOC_FMASK_MASK         8'h27
`define PFOC_IRQ_MASK           8'h07
`define PFOC_RESET_BYTE         8'h00
`endif

// ===== logic/pfoc_pkg.sv
package pfoc_pkg;
  typedef enum logic [2:0] {
    PFOC_RUN     = 3'h1,
    PFOC_FAULTED = 3'h2,
    PFOC_WAITRLD = 3'h4
  } pfoc_state_type;
endpackage

// ===== logic/pfoc_edge.sv
`timescale 1ns/10ps
// Rising edge detector, one per bit
module pfoc_edge (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic [4:0] level_in,
  output logic      [4:0] rise_out
);
  logic [4:0] last;
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_bit
      always_ff @(posedge clock_in) begin
        if (reset_in) begin
          last[g] <= 1'b0;
        end else begin
          last[g] <= level_in[g];
        end
      end
      assign rise_out[g] = level_in[g] & ~last[g];
    end
  endgenerate
endmodule // pfoc_edge

// ===== logic/pfoc_outmux.sv
`timescale 1ns/10ps
// Per-pin output gating: off-state when forced or faulted
module pfoc_outmux (
  input  wire logic [5:0] pwm_in,
  input  wire logic [5:0] off_level_in,
  input  wire logic [5:0] force_off_in,
  input  wire logic       fault_hold_in,
  output logic      [5:0] pin_out
);
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_pin
      assign pin_out[g] = (force_off_in[g] | fault_hold_in) ? off_level_in[g] : pwm_in[g];
    end
  endgenerate
endmodule // pfoc_outmux

// ===== logic/pfoc_top.sv
`timescale 1ns/10ps
`include "pfoc_regs.svh"
//
// Notes on behaviour
// [RQ1] Reload flag bit 7 sets on each timer reload; write one clears.
// [RQ2] Debug flag bit 5 sets on debug entry; write one clears.
// [RQ3] Second fault flag bit 2 sets on that source; write one clears.
// [RQ4] Comparator flag bit 1 sets on comparator assertion; write one clears.
// [RQ5] Pin fault flag bit 0 sets on primary fault input; write one clears.
// [RQ6] Sample register bit 6 reads the live primary fault pin level.
// [RQ7] Sample register bits 5..0 read the six PWM pin levels.
// [RQ8] Override bits 5,3,1 force low-side outputs to off-state.
// [RQ9] Override bits 4,2,0 force high-side outputs to off-state.
// [RQ10] Debug auto recovery resumes when sources clear and next period starts.
// [RQ11] Other sources in auto mode resume as soon as all sources clear.
// [RQ12] Software recovery waits for sources clear, flags clear, then reload.
// [RQ13] Interrupt on second fault if bit 5, on pin fault if bit 1.
// [RQ14] Interrupt on comparator fault only while bit 3 is set.
// [RQ15] A masked fault source produces no PWM fault.
// [RQ16] Debug entry produces a PWM fault unless its mask is set.
// [RQ17] While faulted or recovery pending, all six outputs are held off.
module pfoc_top (
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [15:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        reload_in,
  input  wire logic        debug_in,
  input  wire logic        second_fault_in,
  input  wire logic        comparator_in,
  input  wire logic        primary_fault_input_in,
  input  wire logic [5:0]  pwm_in,
  input  wire logic [5:0]  off_level_in,
  input  wire logic [5:0]  output_pin_level_samples_in,
  output logic      [5:0]  pwm_pin_out,
  output logic             fault_hold_out,
  output logic             irq_out
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0]  fault_status;
  logic [7:0]  output_override;
  logic [7:0]  fault_control;
  logic [7:0]  fault_mask;
  logic [7:0]  irq_status;
  logic [7:0]  irq_enable;
  logic [7:0]  pin_level_sample;
  pfoc_pkg::pfoc_state_type state;
  pfoc_pkg::pfoc_state_type next_state;
  logic [4:0]  rise;
  logic [5:0]  next_pins;
  logic        access;
  logic        wr;
  logic [13:0] index;
  logic        mapped;
  logic [7:0]  wbyte;
  logic        sources_active;
  logic        fault_event;
  logic        sw_recovery;
  logic        sw_recovery_pending;
  logic        flags_clear;
  logic [2:0]  irq_events;
  logic [31:0] next_rdata;

  // ------------------------------------------------------------
  // Event detection
  // ------------------------------------------------------------
  pfoc_edge u_edge (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .level_in ({debug_in, second_fault_in, comparator_in, primary_fault_input_in, 1'b0}),
    .rise_out (rise)
  );

  // rise[4]=debug, [3]=second, [2]=comparator, [1]=pin
  assign sources_active = (second_fault_in & ~fault_mask[`PFOC_BIT_SECOND])         // RQ15
                        | (comparator_in & ~fault_mask[`PFOC_BIT_COMPARATOR])       // RQ15
                        | (primary_fault_input_in & ~fault_mask[`PFOC_BIT_PIN])     // RQ15
                        | (debug_in & ~fault_mask[`PFOC_BIT_DEBUG]);                // RQ16
  assign fault_event = sources_active;

  // Software mode when any recovery bit of an active source is set
  assign sw_recovery = (fault_control[`PFOC_BIT_DBG_RECOVERY] & debug_in)
                     | (fault_control[`PFOC_BIT_SECOND_RECOV] & second_fault_in)
                     | (fault_control[`PFOC_BIT_COMP_RECOV] & comparator_in)
                     | (fault_control[`PFOC_BIT_PIN_RECOV] & primary_fault_input_in);
  assign flags_clear = ((fault_status & 8'h27) == 8'h00);

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign access = psel_in & penable_in;
  assign wr     = access & pwrite_in;
  assign index  = paddr_in[15:2];
  assign wbyte  = pwdata_in[7:0];
  always_comb begin
    mapped     = 1'b1;
    next_rdata = 32'h00000000;
    if (index == {2'b00, `PFOC_IDX_FAULT_STATUS}) begin
      next_rdata[7:0] = fault_status;
    end else if (index == {2'b00, `PFOC_IDX_PIN_LEVEL}) begin
      next_rdata[7:0] = pin_level_sample;
    end else if (index == {2'b00, `PFOC_IDX_OUT_OVERRIDE}) begin
      next_rdata[7:0] = output_override;
    end else if (index == {2'b00, `PFOC_IDX_FAULT_CONTROL}) begin
      next_rdata[7:0] = fault_control;
    end else if (index == {2'b00, `PFOC_IDX_FAULT_MASK}) begin
      next_rdata[7:0] = fault_mask;
    end else if (index == {2'b00, `PFOC_IDX_IRQ_STATUS}) begin
      next_rdata[7:0] = irq_status;
    end else if (index == {2'b00, `PFOC_IDX_IRQ_ENABLE}) begin
      next_rdata[7:0] = irq_enable;
    end else if (index == {2'b00, `PFOC_IDX_IRQ_CLEAR}) begin
      next_rdata[7:0] = 8'h00;
    end else begin
      mapped = 1'b0;
    end
  end

  // Zero-wait slave: ready in access phase
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~mapped;
      prdata_out  <= (psel_in & ~penable_in & ~pwrite_in) ? next_rdata : 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // Fault status flags, set wins over clear
  // ------------------------------------------------------------
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  always_comb begin
    set_bits = 8'h00;
    set_bits[`PFOC_BIT_RELOAD]     = reload_in;  // RQ1
    set_bits[`PFOC_BIT_DEBUG]      = rise[4];    // RQ2
    set_bits[`PFOC_BIT_SECOND]     = rise[3];    // RQ3
    set_bits[`PFOC_BIT_COMPARATOR] = rise[2];    // RQ4
    set_bits[`PFOC_BIT_PIN]        = rise[1];    // RQ5
    clr_bits = 8'h00;
    if (wr && pready_out && index == {2'b00, `PFOC_IDX_FAULT_STATUS}) begin
      clr_bits = wbyte & `PFOC_STATUS_W1C_MASK;
    end
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      fault_status <= `PFOC_RESET_BYTE;
    end else begin
      fault_status <= ((fault_status & ~clr_bits) | set_bits) & `PFOC_STATUS_W1C_MASK; // RQ1
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      output_override <= `PFOC_RESET_BYTE;
      fault_control   <= `PFOC_RESET_BYTE;
      fault_mask      <= `PFOC_RESET_BYTE;
      irq_enable      <= `PFOC_RESET_BYTE;
    end else if (wr && pready_out) begin
      if (index == {2'b00, `PFOC_IDX_OUT_OVERRIDE}) begin
        output_override <= wbyte & `PFOC_OVERRIDE_MASK;
      end else if (index == {2'b00, `PFOC_IDX_FAULT_CONTROL}) begin
        fault_control <= wbyte & `PFOC_CONTROL_MASK;
      end else if (index == {2'b00, `PFOC_IDX_FAULT_MASK}) begin
        fault_mask <= wbyte & `PFOC_FMASK_MASK;
      end else if (index == {2'b00, `PFOC_IDX_IRQ_ENABLE}) begin
        irq_enable <= wbyte & `PFOC_IRQ_MASK;
      end
    end
  end

  // Pin level sampling
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pin_level_sample <= `PFOC_RESET_BYTE;
    end else begin
      pin_level_sample <= {1'b0, primary_fault_input_in, output_pin_level_samples_in}; // RQ6 RQ7
    end
  end

  // ------------------------------------------------------------
  // Interrupts: 0 pin, 1 comparator, 2 second fault
  // ------------------------------------------------------------
  assign irq_events = {rise[3] & fault_control[`PFOC_BIT_SECOND_IRQ],  // RQ13
                       rise[2] & fault_control[`PFOC_BIT_COMP_IRQ],    // RQ14
                       rise[1] & fault_control[`PFOC_BIT_PIN_IRQ]};    // RQ13
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      irq_status <= `PFOC_RESET_BYTE;
    end else if (wr && pready_out && index == {2'b00, `PFOC_IDX_IRQ_CLEAR}) begin
      irq_status <= ((irq_status & ~wbyte) | {5'h00, irq_events}) & `PFOC_IRQ_MASK;
    end else begin
      irq_status <= irq_status | {5'h00, irq_events};
    end
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_enable);
    end
  end

  // ------------------------------------------------------------
  // Recovery state machine
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sw_recovery_pending <= 1'b0;
    end else if (fault_event) begin
      sw_recovery_pending <= sw_recovery;
    end else if (state == pfoc_pkg::PFOC_RUN) begin
      sw_recovery_pending <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      pfoc_pkg::PFOC_RUN: begin
        if (fault_event) begin
          next_state = pfoc_pkg::PFOC_FAULTED;
        end
      end
      pfoc_pkg::PFOC_FAULTED: begin
        if (!fault_event) begin
          if (sw_recovery_pending || fault_control[`PFOC_BIT_DBG_RECOVERY]) begin
            next_state = pfoc_pkg::PFOC_WAITRLD;
          end else if (!(debug_in && !fault_mask[`PFOC_BIT_DEBUG])) begin
            next_state = pfoc_pkg::PFOC_WAITRLD;
          end
        end
      end
      pfoc_pkg::PFOC_WAITRLD: begin
        if (fault_event) begin
          next_state = pfoc_pkg::PFOC_FAULTED;
        end else if (!sw_recovery_pending) begin
          next_state = pfoc_pkg::PFOC_RUN;             // RQ11
        end else if (flags_clear && reload_in) begin
          next_state = pfoc_pkg::PFOC_RUN;             // RQ12
        end
      end
      default: begin
        next_state = pfoc_pkg::PFOC_RUN;
      end
    endcase
  end

  // Debug auto recovery waits for the period start
  logic dbg_wait;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      dbg_wait <= 1'b0;
    end else if (rise[4] && !fault_mask[`PFOC_BIT_DEBUG]) begin
      dbg_wait <= 1'b1;
    end else if (reload_in && !fault_event) begin
      dbg_wait <= 1'b0;                                 // RQ10
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= pfoc_pkg::PFOC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic hold;
  assign hold = (next_state != pfoc_pkg::PFOC_RUN) | (dbg_wait & ~reload_in); // RQ17
  pfoc_outmux u_outmux (
    .pwm_in        (pwm_in),
    .off_level_in  (off_level_in),
    .force_off_in  (output_override[5:0]),  // RQ8 RQ9
    .fault_hold_in (hold),
    .pin_out       (next_pins)
  );
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pwm_pin_out    <= 6'h00;
      fault_hold_out <= 1'b0;
    end else begin
      pwm_pin_out    <= next_pins;
      fault_hold_out <= hold;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence reload_seen;
    reload_in;
  endsequence
  reload_flag_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ1
    reload_seen |=> fault_status[`PFOC_BIT_RELOAD]) else $error("reload flag not set");
  debug_flag_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ2
    rise[4] |=> fault_status[`PFOC_BIT_DEBUG]) else $error("debug flag not set");
  second_flag_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ3
    rise[3] |=> fault_status[`PFOC_BIT_SECOND]) else $error("second flag not set");
  comp_flag_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ4
    rise[2] |=> fault_status[`PFOC_BIT_COMPARATOR]) else $error("comparator flag not set");
  pin_flag_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ5
    (fault_status[`PFOC_BIT_PIN] && !(clr_bits[`PFOC_BIT_PIN])) |=> fault_status[`PFOC_BIT_PIN])
    else $error("pin flag lost");
  level_sample_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ6
    ##1 pin_level_sample[6] == $past(primary_fault_input_in)) else $error("fault level wrong");
  pins_sample_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ7
    ##1 pin_level_sample[5:0] == $past(output_pin_level_samples_in)) else $error("pin level wrong");
  force_off_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ8
    output_override[5] |=> pwm_pin_out[5] == $past(off_level_in[5])) else $error("low side not off");
  high_off_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ9
    output_override[0] |=> pwm_pin_out[0] == $past(off_level_in[0])) else $error("high side not off");
  fault_hold_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ17
    fault_event |=> fault_hold_out) else $error("outputs not held in fault");
  mask_pin_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ15
    (state == pfoc_pkg::PFOC_RUN && fault_mask[0] && primary_fault_input_in && !second_fault_in
     && !comparator_in && !debug_in) |=> state == pfoc_pkg::PFOC_RUN) else $error("masked fault acted");
  comp_irq_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ14
    (rise[2] && fault_control[`PFOC_BIT_COMP_IRQ]) |=> irq_status[1]) else $error("no comparator irq");
  sw_recovery_a: assert property (@(posedge clock_in) disable iff (reset_in) // RQ12
    (state == pfoc_pkg::PFOC_WAITRLD && sw_recovery_pending && !reload_in) |=>
      state != pfoc_pkg::PFOC_RUN) else $error("recovered without reload");
endmodule // pfoc_top

// ===== verif/pfoc_stage.sv
`timescale 1ns/10ps
// Power stage: gate drivers echo the pins, sensors report trips
module pfoc_stage (
  input  wire logic       clock_in,
  input  wire logic [5:0] pin_in,
  input  wire logic [2:0] trip_in,
  output logic      [5:0] level_out,
  output logic      [2:0] sense_out
);
  // Pin levels follow the driven gates
  assign level_out = pin_in;
  // Sensor comparators settle in one clock
  always_ff @(posedge clock_in) begin
    sense_out <= trip_in;
  end
endmodule // pfoc_stage

// ===== verif/tb_pfoc_top.sv
`timescale 1ns/10ps
`include "pfoc_regs.svh"
module tb_pfoc_top;
  logic        clock_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [15:0] paddr    = 16'h0000;
  logic [31:0] pwdata   = 32'h00000000;
  logic        reload   = 1'b0;
  logic        debug    = 1'b0;
  logic [2:0]  trip     = 3'h0;
  logic [5:0]  pwm      = 6'h2A;
  logic [5:0]  off      = 6'h15;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  pin;
  logic [5:0]  levels;
  logic [2:0]  sense;
  logic        hold;
  logic        irq;
  logic [7:0]  rd;
  logic        err;
  int          errors      = 0;
  int          checks_done = 0;

  always #50 clock_in = ~clock_in;

  pfoc_top dut_u (
    .clock_in(clock_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .reload_in(reload), .debug_in(debug),
    .second_fault_in(sense[2]), .comparator_in(sense[1]),
    .primary_fault_input_in(sense[0]), .pwm_in(pwm), .off_level_in(off),
    .output_pin_level_samples_in(levels), .pwm_pin_out(pin), .fault_hold_out(hold),
    .irq_out(irq));

  pfoc_stage stage_u (
    .clock_in(clock_in), .pin_in(pin), .trip_in(trip), .level_out(levels),
    .sense_out(sense));

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task check1(input logic got, input logic exp, input string msg);
    check8({7'h00, got}, {7'h00, exp}, msg);
  endtask

  task ticks(input int n);
    repeat (n) @(posedge clock_in);
    @(negedge clock_in);
  endtask

  // One APB transfer; request held until pready seen at a rising edge
  task xfer(input logic [11:0] idx, input logic wr, input logic [7:0] wd);
    int n;
    @(posedge clock_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clock_in);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clock_in);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      errors++;
      $display("BAD t=%0t no bus answer", $time);
      close_out;
    end
    rd      = prdata[7:0];
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d);
  endtask

  task rd_chk(input logic [11:0] idx, input logic [7:0] mask, input logic [7:0] exp);
    xfer(idx, 1'b0, 8'h00);
    check8(rd & mask, exp, "register read");
  endtask

  task src(input logic [2:0] t, input logic d);
    @(posedge clock_in);
    trip  <= t;
    debug <= d;
    ticks(4);
  endtask

  task pulse_reload;
    @(posedge clock_in);
    reload <= 1'b1;
    @(posedge clock_in);
    reload <= 1'b0;
    ticks(3);
  endtask

  initial begin
    int         i;
    logic [7:0] b;
    logic [5:0] m;
    repeat (10) @(posedge clock_in);
    reset_in <= 1'b0;
    rd_chk(`PFOC_IDX_OUT_OVERRIDE, 8'hFF, 8'h00);
    rd_chk(`PFOC_IDX_FAULT_CONTROL, 8'hFF, 8'h00);
    rd_chk(`PFOC_IDX_PIN_LEVEL, 8'hFF, 8'h2A);
    xfer(12'h100, 1'b0, 8'h00);
    check1(err, 1'b1, "unmapped error");
    check8(rd, 8'h00, "unmapped data");
    $display("test reset done");
    for (i = 0; i < 3; i++) begin
      b = 8'h01 << i;
      src(b[2:0], 1'b0);
      check1(hold, 1'b1, "hold on trip");
      check8({2'b00, pin}, {2'b00, off}, "pins off");
      rd_chk(`PFOC_IDX_FAULT_STATUS, b, b);
      src(3'h0, 1'b0);
      check1(hold, 1'b0, "auto resume");
      rd_chk(`PFOC_IDX_FAULT_STATUS, b, b);
      wr(`PFOC_IDX_FAULT_STATUS, b);
      rd_chk(`PFOC_IDX_FAULT_STATUS, b, 8'h00);
    end
    $display("test sources done");
    src(3'h1, 1'b0);
    rd_chk(`PFOC_IDX_PIN_LEVEL, 8'hFF, 8'h55);
    src(3'h0, 1'b0);
    wr(`PFOC_IDX_FAULT_STATUS, 8'h01);
    $display("test sample done");
    src(3'h0, 1'b1);
    rd_chk(`PFOC_IDX_FAULT_STATUS, 8'h20, 8'h20);
    check1(hold, 1'b1, "debug hold");
    src(3'h0, 1'b0);
    check1(hold, 1'b1, "wait period");
    pulse_reload;
    check1(hold, 1'b0, "period resume");
    rd_chk(`PFOC_IDX_FAULT_STATUS, 8'h80, 8'h80);
    wr(`PFOC_IDX_FAULT_STATUS, 8'hA0);
    rd_chk(`PFOC_IDX_FAULT_STATUS, 8'hA0, 8'h00);
    $display("test debug done");
    wr(`PFOC_IDX_FAULT_CONTROL, 8'h01);
    rd_chk(`PFOC_IDX_FAULT_CONTROL, 8'hFF, 8'h01);
    src(3'h1, 1'b0);
    src(3'h0, 1'b0);
    check1(hold, 1'b1, "no auto resume");
    pulse_reload;
    check1(hold, 1'b1, "flag still set");
    wr(`PFOC_IDX_FAULT_STATUS, 8'hA7);
    ticks(3);
    check1(hold, 1'b1, "await reload");
    pulse_reload;
    check1(hold, 1'b0, "software resume");
    wr(`PFOC_IDX_FAULT_STATUS, 8'h80);
    $display("test software done");
    for (i = 0; i < 6; i++) begin
      m = 6'h01 << i;
      wr(`PFOC_IDX_OUT_OVERRIDE, {2'b00, m});
      ticks(2);
      check8({2'b00, pin}, {2'b00, (pwm & ~m) | (off & m)}, "override pin");
    end
    wr(`PFOC_IDX_OUT_OVERRIDE, 8'hFF);
    rd_chk(`PFOC_IDX_OUT_OVERRIDE, 8'hFF, 8'h3F);
    wr(`PFOC_IDX_OUT_OVERRIDE, 8'h00);
    $display("test override done");
    wr(`PFOC_IDX_FAULT_MASK, 8'h27);
    src(3'h7, 1'b1);
    check1(hold, 1'b0, "masked sources");
    src(3'h0, 1'b0);
    wr(`PFOC_IDX_FAULT_MASK, 8'h00);
    wr(`PFOC_IDX_FAULT_STATUS, 8'hA7);
    $display("test mask done");
    wr(`PFOC_IDX_IRQ_ENABLE, 8'h07);
    wr(`PFOC_IDX_FAULT_CONTROL, 8'h2A);
    for (i = 0; i < 3; i++) begin
      b = 8'h01 << i;
      src(b[2:0], 1'b0);
      check1(irq, 1'b1, "irq raised");
      rd_chk(`PFOC_IDX_IRQ_STATUS, 8'h07, b);
      src(3'h0, 1'b0);
      wr(`PFOC_IDX_IRQ_CLEAR, b);
      ticks(2);
      check1(irq, 1'b0, "irq cleared");
      wr(`PFOC_IDX_FAULT_STATUS, 8'hA7);
    end
    wr(`PFOC_IDX_FAULT_CONTROL, 8'h00);
    src(3'h7, 1'b0);
    check1(irq, 1'b0, "irq disabled");
    src(3'h0, 1'b0);
    wr(`PFOC_IDX_FAULT_CONTROL, 8'h2A);
    wr(`PFOC_IDX_IRQ_ENABLE, 8'h00);
    src(3'h2, 1'b0);
    check1(irq, 1'b0, "irq gated");
    wr(`PFOC_IDX_IRQ_ENABLE, 8'h02);
    ticks(2);
    check1(irq, 1'b1, "irq ungated");
    $display("test irq done");
    close_out;
  end
endmodule // tb_pfoc_top
